/* mcf_pkg.sv */
// Package for the context and fault register bank: offsets, fields, reset values, structs
//
// Behaviour
// - Twelve-bit current context register, 4096 contexts.
// - Cache and translation hits need stored context equal to current context.
// - Reset cause: watchdog bit 2, soft internal bit 1, soft external bit 0.
// - Writing one to soft internal or soft external bit triggers that reset.
// - Reset cause bits clear at power-on and on a read of the reset register.
// - Root pointer valid clears at power-on, context write, context table write.
// - Separate instruction and data level-2 pointers, valid cleared at power-on.
// - Data pointer: value bits 31:4, bits 3:1 reserved, valid bit 0.
// - Index tags: instruction tag bits 31:18, data tag bits 15:2.
// - Replacement and initial replacement counters, both zero at power-on.
// - Synchronous fault raises memory exception with hold and data strobe only.
// - Delayed write-buffer faults are asynchronous; all others synchronous.
// - Copy-back flush walk error sets bit 13, captures missed access address.
// - Sync status bits 12,11,10: uncorrectable, timeout, bus error from bus.
// - Sync status: level 9:8, access kind 7:5, fault kind 4:2.
// - Status bit 1 set when sync fault address is valid.
// - Status bit 0 set on double fault with differing status.
// - Sync status fields clear at power-on and on status read.
// - Synchronous fault captures faulting virtual address.
// - Asynchronous fault asserts the memory error output when the occurred bit is clear.
// - Async fault: address 31:0 in address register, 35:32 in status 7:4.
// - Async occurred bit blocks further capture; reset or either read clears it.
// - Async flags clear at power-on and on status read.
package mcf_pkg;
    // Register addresses within the register space (word aligned)
    localparam logic [7:0] OFF_CONTROL     = 8'h00;
    localparam logic [7:0] OFF_TABLE_BASE  = 8'h01;
    localparam logic [7:0] OFF_CONTEXT     = 8'h02;
    localparam logic [7:0] OFF_RESET       = 8'h03;
    localparam logic [7:0] OFF_ROOT        = 8'h04;
    localparam logic [7:0] OFF_IPTR        = 8'h05;
    localparam logic [7:0] OFF_DPTR        = 8'h06;
    localparam logic [7:0] OFF_TAGS        = 8'h07;
    localparam logic [7:0] OFF_REPL        = 8'h08;
    localparam logic [7:0] OFF_SSTAT       = 8'h13;
    localparam logic [7:0] OFF_SADDR       = 8'h14;
    localparam logic [7:0] OFF_ASTAT       = 8'h15;
    localparam logic [7:0] OFF_AADDR       = 8'h16;
    localparam logic [7:0] REG_ASI         = 8'h04;
    // Field layout
    localparam int CTX_W         = 12;
    localparam int BIT_WDOG      = 2;
    localparam int BIT_SIR       = 1;
    localparam int BIT_SER       = 0;
    localparam int BIT_VALID     = 0;
    localparam int PTR_LSB       = 4;
    localparam int INSTR_POINTER_TAG_LSB      = 18;
    localparam int DATA_POINTER_TAG_LSB      = 2;
    localparam int TAG_W         = 14;
    localparam int CNT_W         = 6;
    localparam int IRC_LSB       = 8;
    localparam int BIT_CBT       = 13;
    localparam int BIT_UC        = 12;
    localparam int BIT_TO        = 11;
    localparam int BIT_BE        = 10;
    localparam int LVL_LSB       = 8;
    localparam int AT_LSB        = 5;
    localparam int FT_LSB        = 2;
    localparam int BIT_FAV       = 1;
    localparam int BIT_OW        = 0;
    localparam int AFA_LSB       = 4;
    localparam int BIT_AFO       = 0;
    // Reset values
    localparam logic [31:0] RST_WORD  = 32'h0000_0000;
    localparam logic [11:0] RST_CTX   = 12'h000;
    localparam logic [5:0]  RST_CNT   = 6'h00;
    localparam logic [2:0]  RST_CAUSE = 3'h0;
    localparam logic [2:0]  RST_FLAGS = 3'h0;
    // Bus error codes: uncorrectable, timeout, bus error
    typedef struct packed {
        logic uc;
        logic tmo;
        logic be;
    } mcf_err_t;
    // Register access from the processor
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  asi;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } mcf_req_t;
    // Synchronous fault report
    typedef struct packed {
        logic        valid;
        logic        copyback;
        logic [1:0]  level;
        logic [2:0]  access_kind;
        logic [2:0]  fault_kind;
        logic [31:0] vaddr;
        mcf_err_t    err;
    } mcf_sfault_t;
    // Asynchronous fault report
    typedef struct packed {
        logic        valid;
        logic        write_buffer;
        logic [35:0] paddr;
        mcf_err_t    err;
    } mcf_afault_t;
endpackage

/* mcf_regs.sv */
// Context, pointer cache, replacement and fault register bank
module mcf_regs
(
    input  wire logic               clk,
    input  wire logic               arst_n,
    input  wire mcf_pkg::mcf_req_t  req,
    output logic [31:0]             rdata,
    output logic                    rvalid,
    input  wire logic               watchdog_event,
    input  wire logic               iptr_load,
    input  wire logic [27:0]        iptr_value,
    input  wire logic [13:0]        iptr_tag,
    input  wire logic               dptr_load,
    input  wire logic [27:0]        dptr_value,
    input  wire logic [13:0]        dptr_tag,
    input  wire logic               root_load,
    input  wire logic [31:0]        root_value,
    input  wire logic               repl_step,
    input  wire mcf_pkg::mcf_sfault_t sfault,
    input  wire logic               sfault_trap_differs,
    input  wire mcf_pkg::mcf_afault_t afault,
    input  wire logic [11:0]        entry_context,
    output logic                    context_match,
    output logic                    soft_internal_reset,
    output logic                    soft_external_reset,
    output logic                    memory_exception_out,
    output logic                    processor_hold_out,
    output logic                    memory_data_strobe,
    output logic                    memory_error_irq,
    output logic [11:0]             current_context
);
    import mcf_pkg::*;

    logic [31:0]      table_base;
    logic [2:0]       reset_cause;
    logic [31:0]      root_pointer;
    logic [31:0]      instr_table_pointer;
    logic [27:0]      data_ptr_value;
    logic             data_ptr_valid;
    logic [TAG_W-1:0] instr_pointer_tag;
    logic [TAG_W-1:0] data_pointer_tag;
    logic [CNT_W-1:0] replacement_counter;
    logic [CNT_W-1:0] initial_replacement_counter;
    logic             copyback_xlate_error;
    mcf_err_t         s_err;
    logic [1:0]       s_level;
    logic [2:0]       access_kind;
    logic [2:0]       fault_kind;
    logic             fault_addr_valid;
    logic             overwrite_flag;
    logic [31:0]      sync_fault_address;
    mcf_err_t         a_err;
    logic [3:0]       async_addr_high;
    logic             async_fault_seen;
    logic [31:0]      async_fault_address;
    logic             acc;
    logic             wr;
    logic             rd;
    logic             async_take;
    logic [31:0]      next_rdata;

    // Only alternate accesses in the register space reach the bank
    assign acc = req.valid && (req.asi == REG_ASI);
    assign wr  = acc && req.write;
    assign rd  = acc && !req.write;
    // Only write-buffer faults are recorded as asynchronous, one at a time
    assign async_take = afault.valid && afault.write_buffer && !async_fault_seen;

    // Current context
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            current_context <= RST_CTX;
        else if (wr && req.addr == OFF_CONTEXT)
            current_context <= req.wdata[CTX_W-1:0];
    end

    // Context qualification of tag and translation hits, registered
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            context_match <= 1'b0;
        else
            context_match <= (entry_context == current_context);
    end

    // Context table base: stored here only for read-back; a write also drops the root entry
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            table_base <= RST_WORD;
        else if (wr && req.addr == OFF_TABLE_BASE)
            table_base <= req.wdata;
    end

    // Reset cause; set wins over a read in the same cycle
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            reset_cause <= RST_CAUSE;
        else
        begin
            reset_cause <= (rd && req.addr == OFF_RESET) ? RST_CAUSE : reset_cause;
            if (watchdog_event)
                reset_cause[BIT_WDOG] <= 1'b1;
            if (wr && req.addr == OFF_RESET)
            begin
                if (req.wdata[BIT_SIR])
                    reset_cause[BIT_SIR] <= 1'b1;
                if (req.wdata[BIT_SER])
                    reset_cause[BIT_SER] <= 1'b1;
            end
        end
    end

    // One-cycle software reset pulses
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            soft_internal_reset <= 1'b0;
            soft_external_reset <= 1'b0;
        end
        else
        begin
            soft_internal_reset <= wr && req.addr == OFF_RESET && req.wdata[BIT_SIR];
            soft_external_reset <= wr && req.addr == OFF_RESET && req.wdata[BIT_SER];
        end
    end

    // Root pointer; context or table base change invalidates it
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            root_pointer <= RST_WORD;
        else if (wr && req.addr == OFF_ROOT)
            root_pointer <= req.wdata;
        else if (wr && (req.addr == OFF_CONTEXT || req.addr == OFF_TABLE_BASE))
            root_pointer[BIT_VALID] <= 1'b0;
        else if (root_load)
            root_pointer <= root_value;
    end

    // Level-2 instruction and data pointers and their index tags
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            instr_table_pointer <= RST_WORD;
            data_ptr_value      <= '0;
            data_ptr_valid      <= 1'b0;
            instr_pointer_tag   <= '0;
            data_pointer_tag    <= '0;
        end
        else
        begin
            if (wr && req.addr == OFF_IPTR)
                instr_table_pointer <= req.wdata;
            else if (iptr_load)
            begin
                instr_table_pointer <= {iptr_value, 3'b000, 1'b1};
                instr_pointer_tag   <= iptr_tag;
            end
            if (wr && req.addr == OFF_DPTR)
            begin
                data_ptr_value <= req.wdata[31:PTR_LSB];
                data_ptr_valid <= req.wdata[BIT_VALID];
            end
            else if (dptr_load)
            begin
                data_ptr_value   <= dptr_value;
                data_ptr_valid   <= 1'b1;
                data_pointer_tag <= dptr_tag;
            end
            if (wr && req.addr == OFF_TAGS)
            begin
                instr_pointer_tag <= req.wdata[31:INSTR_POINTER_TAG_LSB];
                data_pointer_tag  <= req.wdata[DATA_POINTER_TAG_LSB+TAG_W-1:DATA_POINTER_TAG_LSB];
            end
        end
    end

    // Replacement counters; counter wraps back to the initial value
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            replacement_counter         <= RST_CNT;
            initial_replacement_counter <= RST_CNT;
        end
        else if (wr && req.addr == OFF_REPL)
        begin
            replacement_counter         <= req.wdata[CNT_W-1:0];
            initial_replacement_counter <= req.wdata[IRC_LSB+CNT_W-1:IRC_LSB];
        end
        else if (repl_step)
            replacement_counter <= (&replacement_counter) ? initial_replacement_counter
                                 : replacement_counter + 6'h01;
    end

    // Synchronous fault status and address; a new fault wins over a clearing read
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            copyback_xlate_error <= 1'b0;
            s_err                <= RST_FLAGS;
            s_level              <= '0;
            access_kind          <= '0;
            fault_kind           <= '0;
            fault_addr_valid     <= 1'b0;
            overwrite_flag       <= 1'b0;
            sync_fault_address   <= RST_WORD;
        end
        else if (sfault.valid)
        begin
            copyback_xlate_error <= sfault.copyback;
            s_err                <= sfault.err;
            s_level              <= sfault.level;
            access_kind          <= sfault.access_kind;
            fault_kind           <= sfault.fault_kind;
            sync_fault_address   <= sfault.vaddr;
            fault_addr_valid     <= 1'b1;
            overwrite_flag       <= fault_addr_valid && sfault_trap_differs;
        end
        else if (rd && req.addr == OFF_SSTAT)
        begin
            copyback_xlate_error <= 1'b0;
            s_err                <= RST_FLAGS;
            s_level              <= '0;
            access_kind          <= '0;
            fault_kind           <= '0;
            fault_addr_valid     <= 1'b0;
            overwrite_flag       <= 1'b0;
        end
    end

    // Exception to the processor for synchronous faults only
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            memory_exception_out <= 1'b0;
            processor_hold_out   <= 1'b0;
            memory_data_strobe   <= 1'b0;
        end
        else
        begin
            memory_exception_out <= sfault.valid;
            processor_hold_out   <= sfault.valid;
            memory_data_strobe   <= sfault.valid;
        end
    end

    // Asynchronous fault capture; capture wins over a clearing read
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            a_err               <= RST_FLAGS;
            async_addr_high     <= '0;
            async_fault_seen    <= 1'b0;
            async_fault_address <= RST_WORD;
        end
        else if (async_take)
        begin
            a_err               <= afault.err;
            async_addr_high     <= afault.paddr[35:32];
            async_fault_address <= afault.paddr[31:0];
            async_fault_seen    <= 1'b1;
        end
        else if (rd && req.addr == OFF_ASTAT)
        begin
            a_err            <= RST_FLAGS;
            async_fault_seen <= 1'b0;
        end
        else if (rd && req.addr == OFF_AADDR)
            async_fault_seen <= 1'b0;
    end

    // Memory error pulse for asynchronous faults
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            memory_error_irq <= 1'b0;
        else
            memory_error_irq <= async_take;
    end

    // Read mux; reserved bits and unmapped addresses read zero
    always_comb
    begin
        next_rdata = RST_WORD;
        case (req.addr)
            OFF_TABLE_BASE: next_rdata = table_base;
            OFF_CONTEXT:    next_rdata[CTX_W-1:0] = current_context;
            OFF_RESET:      next_rdata[2:0] = reset_cause;
            OFF_ROOT:       next_rdata = root_pointer;
            OFF_IPTR:       next_rdata = instr_table_pointer;
            OFF_DPTR:       next_rdata = {data_ptr_value, 3'b000, data_ptr_valid};
            OFF_TAGS:       next_rdata = {instr_pointer_tag, 2'b00, data_pointer_tag, 2'b00};
            OFF_REPL:
            begin
                next_rdata[CNT_W-1:0] = replacement_counter;
                next_rdata[IRC_LSB+CNT_W-1:IRC_LSB] = initial_replacement_counter;
            end
            OFF_SSTAT:      next_rdata = {18'h0, copyback_xlate_error, s_err, s_level,
                                          access_kind, fault_kind, fault_addr_valid,
                                          overwrite_flag};
            OFF_SADDR:      next_rdata = sync_fault_address;
            OFF_ASTAT:      next_rdata = {19'h0, a_err, 2'b00, async_addr_high, 3'b000,
                                          async_fault_seen};
            OFF_AADDR:      next_rdata = async_fault_address;
            default:        next_rdata = RST_WORD;
        endcase
    end

    // Registered read answer, one cycle after the request
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rdata  <= RST_WORD;
            rvalid <= 1'b0;
        end
        else
        begin
            rvalid <= rd;
            rdata  <= rd ? next_rdata : RST_WORD;
        end
    end
endmodule // mcf_regs

/* mcf_regs_properties.sv */
// Checker for the context and fault register bank, bound to its ports
module mcf_regs_properties
(
    input wire logic                 clk,
    input wire logic                 arst_n,
    input wire mcf_pkg::mcf_req_t    req,
    input wire logic [31:0]          rdata,
    input wire logic                 rvalid,
    input wire logic                 watchdog_event,
    input wire mcf_pkg::mcf_sfault_t sfault,
    input wire mcf_pkg::mcf_afault_t afault,
    input wire logic [11:0]          entry_context,
    input wire logic                 context_match,
    input wire logic                 soft_internal_reset,
    input wire logic                 soft_external_reset,
    input wire logic                 memory_exception_out,
    input wire logic                 processor_hold_out,
    input wire logic                 memory_data_strobe,
    input wire logic                 memory_error_irq,
    input wire logic [11:0]          current_context
);
    timeunit 1ns;
    timeprecision 1ps;
    import mcf_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Accesses decoded the way the bank takes them; other spaces never count
    wire acc    = req.valid && req.asi == REG_ASI;
    wire rd     = acc && !req.write;
    wire wr     = acc && req.write;
    wire rd_rst = rd && req.addr == OFF_RESET;
    wire rd_ss  = rd && req.addr == OFF_SSTAT;
    wire wr_rst = wr && req.addr == OFF_RESET;
    a_read_answer: assert property (rd |=> rvalid)
        else $error("read got no answer");
    a_answer_cause: assert property (rvalid |-> $past(rd))
        else $error("answer without a taken read");
    a_sir_pulse: assert property (wr_rst && req.wdata[BIT_SIR] |=> soft_internal_reset)
        else $error("internal reset not pulsed");
    a_ser_cause: assert property (soft_external_reset |-> $past(wr_rst && req.wdata[BIT_SER]))
        else $error("external reset without its write");
    a_ctx_write: assert property (wr && req.addr == OFF_CONTEXT
        |=> current_context == $past(req.wdata[11:0]))
        else $error("context not loaded");
    a_ctx_compare: assert property ($past(arst_n)
        |-> context_match == $past(entry_context == current_context))
        else $error("context match wrong");
    a_exc_trio: assert property (sfault.valid
        |=> memory_exception_out && processor_hold_out && memory_data_strobe)
        else $error("exception trio missing");
    a_exc_cause: assert property (memory_exception_out |-> $past(sfault.valid))
        else $error("exception without sync fault");
    a_irq_cause: assert property (memory_error_irq |-> $past(afault.valid && afault.write_buffer))
        else $error("memory error without write buffer fault");
    // A write in the gap may set a cause bit again, so it must stay out of the window
    a_cause_clear: assert property (rd_rst && !watchdog_event ##1 !watchdog_event && !wr_rst ##1 rd_rst
        |=> rdata == 32'h0)
        else $error("reset cause not cleared by read");
    a_sstat_clear: assert property (rd_ss && !sfault.valid ##1 !sfault.valid ##1 rd_ss
        |=> rdata == 32'h0)
        else $error("sync status not cleared by read");
    // Main scenarios reached
    c_sstat_read: cover property (rd_ss ##1 rvalid);
    c_async_irq: cover property (afault.valid ##1 memory_error_irq);
    c_soft_reset: cover property (soft_internal_reset);
endmodule // mcf_regs_properties

bind mcf_regs mcf_regs_properties u_props (.*);

/* mcf_cpu_model.sv */
// Processor model issuing alternate-space register accesses
module mcf_cpu_model
(
    input  wire logic         clk,
    output mcf_pkg::mcf_req_t req,
    input  wire logic [31:0]  rdata,
    input  wire logic         rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    import mcf_pkg::*;
    initial req = '0;
    // One access: held until the taking edge, then released with scrambled
    // address and data so a stale value cannot pass for a held one
    task automatic access(input logic w, input logic [7:0] asi, input logic [7:0] a,
                          input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        req <= '{1'b1, w, asi, a, d};
        @(posedge clk);
        req.valid <= 1'b0;
        req.addr  <= ~a;
        req.wdata <= ~d;
        #1;
        q = rvalid ? rdata : 32'hDEAD_BEEF;
    endtask
    // Register accesses always use the register space
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        access(1'b1, REG_ASI, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        access(1'b0, REG_ASI, a, 32'h0, q);
    endtask
endmodule // mcf_cpu_model

/* mcf_regs_tb.sv */
// Self-checking bench for the context and fault register bank
module mcf_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import mcf_pkg::*;
    logic        clk = 1'b0, arst_n = 1'b0, watchdog_event = 1'b0;
    logic        iptr_load = 1'b0, dptr_load = 1'b0, root_load = 1'b0, repl_step = 1'b0;
    logic [27:0] iptr_value = '0, dptr_value = '0;
    logic [13:0] iptr_tag = '0, dptr_tag = '0;
    logic [31:0] root_value = '0, rdata, q;
    mcf_req_t    req;
    mcf_sfault_t sfault = '0;
    mcf_afault_t afault = '0;
    logic        sfault_trap_differs = 1'b0, rvalid, context_match;
    logic        soft_internal_reset, soft_external_reset, memory_exception_out;
    logic        processor_hold_out, memory_data_strobe, memory_error_irq;
    logic [11:0] entry_context = '0, current_context;
    int          errors = 0, cmp_count = 0, cycles = 0;

    mcf_regs u_dut (.*);
    mcf_cpu_model u_cpu (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));

    always #2.5 clk = ~clk;
    // Cut a hang short; the whole run needs well under a thousand cycles
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            errors++;
            close_out();
        end
    end
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        u_cpu.rd(a, q);
        check(q, exp);
    endtask
    // Fault pulses; outputs are looked at one settled instant after the taking edge
    task automatic sf_pulse(input mcf_sfault_t f, input logic d);
        @(posedge clk);
        sfault <= f;
        sfault_trap_differs <= d;
        @(posedge clk);
        sfault.valid <= 1'b0;
        #1;
    endtask
    task automatic af_pulse(input mcf_afault_t f);
        @(posedge clk);
        afault <= f;
        @(posedge clk);
        afault.valid <= 1'b0;
        #1;
    endtask
    task automatic t_reset_values();
        logic [7:0] offs [11] = '{OFF_CONTEXT, OFF_RESET, OFF_ROOT, OFF_IPTR, OFF_DPTR,
            OFF_TAGS, OFF_REPL, OFF_SSTAT, OFF_SADDR, OFF_ASTAT, OFF_AADDR};
        foreach (offs[i])
            rd_chk(offs[i], RST_WORD);
        rd_chk(8'h30, 32'h0);
        u_cpu.access(1'b0, 8'h05, OFF_CONTEXT, 32'h0, q);
        check(q, 32'hDEAD_BEEF);
    endtask
    task automatic t_context_root();
        @(posedge clk);
        root_load  <= 1'b1;
        root_value <= 32'h1234_5601;
        @(posedge clk) root_load <= 1'b0;
        rd_chk(OFF_ROOT, 32'h1234_5601);
        u_cpu.wr(OFF_CONTEXT, 32'hFFFF_FABC);
        rd_chk(OFF_ROOT, 32'h1234_5600);
        rd_chk(OFF_CONTEXT, 32'h0000_0ABC);
        u_cpu.wr(OFF_ROOT, 32'hCAFE_0001);
        u_cpu.wr(OFF_TABLE_BASE, 32'h0000_0100);
        rd_chk(OFF_ROOT, 32'hCAFE_0000);
        rd_chk(OFF_TABLE_BASE, 32'h0000_0100);
        @(posedge clk) entry_context <= 12'hABC;
        repeat (2) @(posedge clk);
        #1 check(context_match, 1'b1);
        @(posedge clk) entry_context <= 12'h2BC;
        repeat (2) @(posedge clk);
        #1 check(context_match, 1'b0);
    endtask
    task automatic t_pointers();
        @(posedge clk);
        iptr_load  <= 1'b1;
        iptr_value <= 28'hABC_DEF1;
        iptr_tag   <= 14'h3A5C;
        dptr_load  <= 1'b1;
        dptr_value <= 28'h123_4567;
        dptr_tag   <= 14'h1234;
        @(posedge clk);
        iptr_load <= 1'b0;
        dptr_load <= 1'b0;
        rd_chk(OFF_IPTR, 32'hABCD_EF11);
        rd_chk(OFF_DPTR, 32'h1234_5671);
        rd_chk(OFF_TAGS, {14'h3A5C, 2'b0, 14'h1234, 2'b0});
        u_cpu.wr(OFF_DPTR, 32'hFFFF_FFFF);
        rd_chk(OFF_DPTR, 32'hFFFF_FFF1);
        u_cpu.wr(OFF_TAGS, 32'hFFFF_FFFF);
        rd_chk(OFF_TAGS, 32'hFFFC_FFFC);
        u_cpu.wr(OFF_REPL, 32'h0000_053E);
        rd_chk(OFF_REPL, 32'h0000_053E);
        @(posedge clk) repl_step <= 1'b1;
        repeat (2) @(posedge clk);
        repl_step <= 1'b0;
        rd_chk(OFF_REPL, 32'h0000_0505);
    endtask
    task automatic t_reset_reg();
        @(posedge clk) watchdog_event <= 1'b1;
        @(posedge clk) watchdog_event <= 1'b0;
        rd_chk(OFF_RESET, 32'h4);
        rd_chk(OFF_RESET, 32'h0);
        u_cpu.wr(OFF_RESET, 32'h2);
        check({soft_internal_reset, soft_external_reset}, 2'b10);
        rd_chk(OFF_RESET, 32'h2);
        u_cpu.wr(OFF_RESET, 32'h1);
        check({soft_internal_reset, soft_external_reset}, 2'b01);
        rd_chk(OFF_RESET, 32'h1);
        rd_chk(OFF_RESET, 32'h0);
    endtask
    task automatic t_sync();
        sf_pulse('{1'b1, 1'b1, 2'd2, 3'd5, 3'd3, 32'h8765_4320, '{1'b1, 1'b0, 1'b1}}, 1'b0);
        check({memory_exception_out, processor_hold_out, memory_data_strobe}, 3'b111);
        check(memory_error_irq, 1'b0);
        sf_pulse('{1'b1, 1'b1, 2'd2, 3'd5, 3'd3, 32'h8765_4320, '{1'b1, 1'b0, 1'b1}}, 1'b1);
        rd_chk(OFF_SADDR, 32'h8765_4320);
        rd_chk(OFF_SSTAT, {18'h0, 6'b110110, 3'd5, 3'd3, 2'b11});
        rd_chk(OFF_SSTAT, 32'h0);
        sf_pulse('{1'b1, 1'b0, 2'd1, 3'd2, 3'd6, 32'h0000_0FF8, '{1'b0, 1'b1, 1'b0}}, 1'b1);
        rd_chk(OFF_SSTAT, {18'h0, 6'b001001, 3'd2, 3'd6, 2'b10});
    endtask
    task automatic t_async();
        af_pulse('{1'b1, 1'b0, 36'h0_0000_1000, '{1'b0, 1'b1, 1'b0}});
        check(memory_error_irq, 1'b0);
        rd_chk(OFF_ASTAT, 32'h0);
        af_pulse('{1'b1, 1'b1, 36'hA_1234_5678, '{1'b1, 1'b0, 1'b1}});
        check({memory_error_irq, memory_exception_out}, 2'b10);
        af_pulse('{1'b1, 1'b1, 36'h5_0000_0010, '{1'b0, 1'b1, 1'b0}});
        check(memory_error_irq, 1'b0);
        rd_chk(OFF_AADDR, 32'h1234_5678);
        rd_chk(OFF_ASTAT, 32'h0000_14A0);
        af_pulse('{1'b1, 1'b1, 36'h5_0000_0010, '{1'b0, 1'b1, 1'b0}});
        check(memory_error_irq, 1'b1);
        rd_chk(OFF_ASTAT, 32'h0000_0851);
    endtask
    // A second reset in mid-run must bring the bank back to its power-on state
    task automatic t_rerun_reset();
        @(posedge clk) arst_n <= 1'b0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        check(current_context, 12'h000);
        rd_chk(OFF_REPL, 32'h0);
        rd_chk(OFF_IPTR, 32'h0);
    endtask

    initial
    begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        t_reset_values();
        t_context_root();
        t_pointers();
        t_reset_reg();
        t_sync();
        t_async();
        t_rerun_reset();
        close_out();
    end
endmodule // mcf_regs_tb
